//--- sim/scb_reader.sv
// reader model: free-running read clock and readout request pin
`timescale 1ns/1ps
module scb_reader (
	input wire logic go, // bench asks for a readout
	output logic read_clock, // reader's read clock
	output logic readout_request // request pin toward the block
);
	// clock never stops, request changes only on read clock rises
	initial begin
		read_clock = 1'b0;
		readout_request = 1'b0;
		#3.3;
		fork
			forever #62.5 read_clock = ~read_clock;
			forever @(posedge read_clock) readout_request <= go;
		join
	end
endmodule

//--- sim/test_sample_capture_buffer_with_test_pattern.sv
// self-checking bench for the capture buffer block
`timescale 1ns/1ps
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t %s", $time, m); end end
module test_sample_capture_buffer_with_test_pattern;
	import scb_pkg::*;
	logic clock, rstn, go, capture_request, readout_request, read_clock, buffer_reset, converter_over_range;
	logic [15:0] cbc;
	logic [7:0] converter_data, prim, sec, d0;
	logic sec_oe, output_strobe, overrange, capture_empty_flag, capture_full_flag, capture_start_marker;
	int errors = 0;
	int cmp_count = 0;

	scb_top dut (
		.clock(clock), .rstn(rstn), .capture_buffer_control(cbc), .converter_data(converter_data),
		.converter_over_range(converter_over_range), .capture_request(capture_request),
		.readout_request(readout_request), .read_clock(read_clock), .buffer_reset(buffer_reset),
		.primary_output_port(prim), .secondary_output_port(sec), .secondary_output_enable(sec_oe),
		.output_strobe(output_strobe), .overrange(overrange), .capture_empty_flag(capture_empty_flag),
		.capture_full_flag(capture_full_flag), .capture_start_marker(capture_start_marker)
	);
	scb_reader reader (.go(go), .read_clock(read_clock), .readout_request(readout_request));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// ramp data makes every stored byte traceable to its slot
	always @(posedge clock) converter_data <= converter_data + 8'h01;

	task automatic test_done();
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic logic flag(input int sel);
		return sel == 0 ? capture_empty_flag : capture_full_flag;
	endfunction

	// bounded wait on a flag, a timeout ends the run
	task automatic wait_lvl(input int sel, input logic v, input int n);
		int i;
		for (i = 0; i < n && flag(sel) !== v; i++) begin
			@(posedge clock);
			#1;
		end
		if (flag(sel) !== v) begin
			errors++;
			$display("[ERR] %0t wait ran out", $time);
			test_done();
		end
	endtask

	// fill the buffer, optionally with one out-of-range sample, hold request extra cycles
	task automatic capture(input logic [15:0] ctl, input int depth, input logic orp, input int extra);
		int d;
		@(posedge clock);
		cbc <= ctl;
		@(posedge clock);
		capture_request <= 1'b1;
		wait_lvl(0, 1'b0, 10);
		`CHK(capture_start_marker, 1'b1, "start marker")
		d0 = converter_data;
		for (d = 0; d < 5000 && capture_full_flag !== 1'b1; d++) begin
			@(posedge clock);
			converter_over_range <= orp && d == 100;
			#1;
		end
		wait_lvl(1, 1'b1, 1);
		`CHK(d, depth, "fill count")
		repeat (extra + 1) @(posedge clock);
		`CHK(capture_full_flag, 1'b1, "full held")
		capture_request <= 1'b0;
		repeat (8) @(posedge clock);
	endtask

	// read everything back and judge each word as its strobe transition comes
	task automatic readout(input logic dual, input logic pat, input logic ovr, input int depth, input logic stop);
		int words, rises, n, i;
		logic ls, lr, lq;
		logic [7:0] prev;
		words = 0;
		rises = 0;
		n = dual ? depth / 2 : depth;
		ls = output_strobe;
		lr = read_clock;
		lq = readout_request;
		go <= 1'b1;
		for (i = 0; i < 27000 && capture_empty_flag !== 1'b1; i++) begin
			@(posedge clock);
			#1;
			if (read_clock && !lr && lq && words == 0)
				rises++;
			lr = read_clock;
			lq = readout_request;
			if (i == 20)
				`CHK(capture_full_flag, 1'b0, "full cleared")
			if (output_strobe !== ls) begin
				ls = output_strobe;
				`CHK(sec_oe, dual, "secondary enable")
				if (words < n - 1)
					`CHK(overrange, ovr, "overrange level")
				if (pat && dual) begin
					`CHK(sec, PATTERN[(2 * words) % 8], "pattern sec")
					`CHK(prim, PATTERN[(2 * words + 1) % 8], "pattern prim")
				end else if (pat) begin
					`CHK(prim, PATTERN[words % 8], "pattern single")
				end else begin
					if (words == 0) begin
						`CHK(rises, 3, "first word latency")
						if (stop)
							`CHK(8'(((dual ? sec : prim) - d0 + 8'h01) & 8'hFC), 8'h00, "oldest first")
					end else begin
						`CHK(dual ? sec : prim, 8'(prev + 8'h01), "byte order")
					end
					if (dual)
						`CHK(prim, 8'(sec + 8'h01), "secondary first")
					prev = prim;
				end
				words++;
			end
		end
		wait_lvl(0, 1'b1, 1);
		`CHK(words, n, "word count")
		`CHK(overrange, 1'b0, "overrange cleared")
		repeat (300) @(posedge clock);
		`CHK(output_strobe, ls, "no re-read")
		go <= 1'b0;
		repeat (20) @(posedge clock);
	endtask

	task automatic test_reset();
		`CHK(capture_empty_flag, 1'b1, "empty at reset")
		`CHK(capture_full_flag, 1'b0, "full at reset")
		$display("done: reset");
	endtask

	task automatic test_single_stop();
		capture(16'h27FF, 512, 1'b1, 300);
		readout(1'b0, 1'b0, 1'b1, 512, 1'b1);
		$display("done: single stop");
	endtask

	task automatic test_single_pattern();
		capture(16'h6FFF, 1024, 1'b0, 0);
		readout(1'b0, 1'b1, 1'b1, 1024, 1'b1);
		$display("done: single pattern");
	endtask

	task automatic test_dual_wrap();
		capture(16'h97FF, 2048, 1'b0, 300);
		readout(1'b1, 1'b0, 1'b0, 2048, 1'b0);
		$display("done: dual wrap");
	endtask

	task automatic test_dual_pattern();
		capture(16'hFFFF, 4096, 1'b0, 0);
		readout(1'b1, 1'b1, 1'b1, 4096, 1'b1);
		$display("done: dual pattern");
	endtask

	// capture request during readout freezes the buffer until reset
	task automatic test_freeze_reset();
		logic s;
		capture(16'h27FF, 512, 1'b0, 0);
		go <= 1'b1;
		repeat (300) @(posedge clock);
		capture_request <= 1'b1;
		repeat (20) @(posedge clock);
		s = output_strobe;
		repeat (300) @(posedge clock);
		`CHK(output_strobe, s, "frozen strobe")
		`CHK(capture_empty_flag, 1'b0, "frozen empty")
		go <= 1'b0;
		capture_request <= 1'b0;
		buffer_reset <= 1'b1;
		repeat (4) @(posedge clock);
		buffer_reset <= 1'b0;
		wait_lvl(0, 1'b1, 20);
		`CHK(capture_full_flag, 1'b0, "full after abort")
		$display("done: freeze and reset");
	endtask

	initial begin
		rstn = 1'b0;
		go = 1'b0;
		cbc = 16'h27FF;
		converter_data = 8'h00;
		converter_over_range = 1'b0;
		capture_request = 1'b0;
		buffer_reset = 1'b0;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
		#1;
		test_reset();
		test_single_stop();
		test_single_pattern();
		test_dual_wrap();
		test_dual_pattern();
		test_freeze_reset();
		test_single_stop();
		test_done();
	end
endmodule

//--- verilog/scb_mem_if.sv
// connection between the buffer controller and its storage array
`timescale 1ns/1ps
interface scb_mem_if;
	import scb_pkg::*;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [ADDR_W-1:0] rd_addr_a;
	logic [ADDR_W-1:0] rd_addr_b;
	logic [DATA_W-1:0] rd_data_a;
	logic [DATA_W-1:0] rd_data_b;

	modport ctrl (output wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b, input rd_data_a, rd_data_b);
	modport store (input wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b, output rd_data_a, rd_data_b);
endinterface

//--- verilog/scb_pkg.sv
// constants, field layout and types shared by the capture buffer design
package scb_pkg;

	// capture buffer control register location and field positions
	localparam logic [3:0] CBC_OFFSET = 4'hF;
	localparam int CBC_WIDTH = 16;
	localparam int CBC_DEPTH_HI = 15;
	localparam int CBC_DEPTH_LO = 14;
	localparam int CBC_STOP_BIT = 13;
	localparam int CBC_DUAL_BIT = 12;
	localparam int CBC_PATTERN_BIT = 11;
	// power-on values of the documented fields, for software reference
	localparam logic [15:0] CBC_POR_VALUE = 16'hE7FF;

	// storage geometry
	localparam int ADDR_W = 12;
	localparam int COUNT_W = 13;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 4096;
	localparam logic [COUNT_W-1:0] DEPTH_MIN = 13'h0200;

	// read clock edges from readout request to first word
	localparam logic [1:0] READ_LATENCY = 2'h3;

	// byte steps per output transfer
	localparam logic [ADDR_W-1:0] STEP_ONE = 12'h001;
	localparam logic [ADDR_W-1:0] STEP_TWO = 12'h002;

	// test pattern, in output order
	localparam int PAT_LEN = 8;
	localparam logic [0:PAT_LEN-1][DATA_W-1:0] PATTERN = {
		8'h01, 8'h02, 8'h03, 8'h04, 8'hFE, 8'hFD, 8'hFC, 8'hFB
	};

	typedef enum logic [2:0] {
		SCB_IDLE,
		SCB_CAPTURE,
		SCB_FULL,
		SCB_READ,
		SCB_FROZEN
	} scb_mode_t;

	typedef logic [MEM_DEPTH-1:0][DATA_W-1:0] scb_mem_t;

endpackage

//--- verilog/scb_store.sv
// flip-flop storage array with one write port and two read ports
`timescale 1ns/1ps
module scb_store
	import scb_pkg::*;
(
	input wire logic clock, // sample clock
	scb_mem_if.store mem // controller side
);

	typedef struct packed {
		scb_mem_t cells;
	} scb_store_state_t;

	scb_store_state_t cur;
	scb_store_state_t next_cur;

	// data cells carry no reset: contents are only read after a full capture
	always_comb begin
		next_cur = cur;
		if (mem.wr_en) begin
			next_cur.cells[mem.wr_addr] = mem.wr_data;
		end
	end

	always_ff @(posedge clock) begin
		cur <= next_cur;
	end

	// reads are combinational; the controller registers them on the way out
	assign mem.rd_data_a = cur.cells[mem.rd_addr_a];
	assign mem.rd_data_b = cur.cells[mem.rd_addr_b];

endmodule

//--- verilog/scb_top.sv
// one-shot capture buffer with test pattern generator
`timescale 1ns/1ps
module scb_top
	import scb_pkg::*;
(
	input wire logic clock, // sample clock, also write clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic [CBC_WIDTH-1:0] capture_buffer_control, // control register contents
	input wire logic [DATA_W-1:0] converter_data, // converted sample
	input wire logic converter_over_range, // sample out of range
	input wire logic capture_request, // write enable pin, asynchronous
	input wire logic readout_request, // read enable pin, asynchronous
	input wire logic read_clock, // reader's free-running clock pin
	input wire logic buffer_reset, // reset pin, active high, asynchronous
	output logic [DATA_W-1:0] primary_output_port, // primary data
	output logic [DATA_W-1:0] secondary_output_port, // secondary data
	output logic secondary_output_enable, // high while secondary drives
	output logic output_strobe, // toggles with each new word
	output logic overrange, // latched out-of-range flag; in pattern mode high for the whole readout instead
	output logic capture_empty_flag, // buffer read out
	output logic capture_full_flag, // buffer filled
	output logic capture_start_marker // resynchronised capture request
);

	typedef struct packed {
		logic wen_meta;
		logic wen_sync;
		logic ren_meta;
		logic ren_sync;
		logic rst_meta;
		logic rst_sync;
		logic rck_meta;
		logic rck_sync;
		logic rck_prev;
		scb_mode_t mode;
		logic [ADDR_W-1:0] wr_ptr;
		logic [COUNT_W-1:0] wr_count;
		logic [ADDR_W-1:0] rd_ptr;
		logic [COUNT_W-1:0] rd_left;
		logic [1:0] lat_cnt;
		logic [2:0] pat_idx;
		logic full;
		logic empty;
		logic ovr;
		logic strobe;
		logic [DATA_W-1:0] prim;
		logic [DATA_W-1:0] sec;
		logic sec_oe;
		logic marker;
	} scb_state_t;

	scb_state_t cur;
	scb_state_t next_cur;

	scb_mem_if mem ();

	scb_store u_store (
		.clock(clock),
		.mem(mem)
	);

	// configuration fields
	logic cfg_pattern;
	logic cfg_dual;
	logic cfg_stop;
	logic [1:0] cfg_depth;
	logic [COUNT_W-1:0] depth_bytes;
	logic [ADDR_W-1:0] addr_mask;
	logic rck_rise;
	logic write_now;
	logic [ADDR_W-1:0] step;

	assign cfg_pattern = capture_buffer_control[CBC_PATTERN_BIT];
	assign cfg_dual = capture_buffer_control[CBC_DUAL_BIT];
	assign cfg_stop = capture_buffer_control[CBC_STOP_BIT];
	assign cfg_depth = capture_buffer_control[CBC_DEPTH_HI:CBC_DEPTH_LO];

	// depth doubles per select step from the smallest size
	assign depth_bytes = DEPTH_MIN << cfg_depth;
	assign addr_mask = ADDR_W'(depth_bytes - 13'h0001);

	// read clock edge seen only through the synchronised copies
	assign rck_rise = cur.rck_sync & ~cur.rck_prev;

	// writing is allowed only in capture, and not once full under auto-stop
	assign write_now = (cur.mode == SCB_CAPTURE) && cur.wen_sync && !cur.rst_sync
		&& !(cur.full && cfg_stop);

	// two bytes per transfer in two-port mode
	assign step = cfg_dual ? STEP_TWO : STEP_ONE;

	// storage ports
	assign mem.wr_en = write_now;
	assign mem.wr_addr = cur.wr_ptr;
	assign mem.wr_data = converter_data;
	assign mem.rd_addr_a = cur.rd_ptr;
	assign mem.rd_addr_b = (cur.rd_ptr + STEP_ONE) & addr_mask;

	// next-state logic for the whole controller
	always_comb begin
		next_cur = cur;
		// two-flop synchronisers for every pin from outside this clock
		next_cur.wen_meta = capture_request;
		next_cur.wen_sync = cur.wen_meta;
		next_cur.ren_meta = readout_request;
		next_cur.ren_sync = cur.ren_meta;
		next_cur.rst_meta = buffer_reset;
		next_cur.rst_sync = cur.rst_meta;
		next_cur.rck_meta = read_clock;
		next_cur.rck_sync = cur.rck_meta;
		next_cur.rck_prev = cur.rck_sync;
		next_cur.marker = cur.wen_sync;

		if (cur.rst_sync) begin
			// pin reset aborts capture and readout and returns to empty
			next_cur.mode = SCB_IDLE;
			next_cur.full = 1'b0;
			next_cur.empty = 1'b1;
			next_cur.ovr = 1'b0;
			next_cur.wr_ptr = '0;
			next_cur.wr_count = '0;
			next_cur.lat_cnt = '0;
		end else begin
			unique case (cur.mode)
				SCB_IDLE: begin
					// a new capture can only begin from the empty state
					if (cur.wen_sync) begin
						next_cur.mode = SCB_CAPTURE;
						next_cur.empty = 1'b0;
						next_cur.full = 1'b0;
						next_cur.wr_ptr = '0;
						next_cur.wr_count = '0;
						next_cur.ovr = 1'b0;
					end
				end
				SCB_CAPTURE: begin
					if (write_now) begin
						// pointer wraps within the selected depth, so the oldest sample is overwritten
						next_cur.wr_ptr = (cur.wr_ptr + STEP_ONE) & addr_mask;
						if (!cur.full) begin
							next_cur.wr_count = cur.wr_count + 13'h0001;
							if (cur.wr_count + 13'h0001 == depth_bytes) begin
								next_cur.full = 1'b1;
							end
						end
						if (converter_over_range && !cfg_pattern) begin
							next_cur.ovr = 1'b1;
						end
					end
					// leave capture once full and writing has stopped
					if (cur.full && (!cur.wen_sync || cfg_stop)) begin
						next_cur.mode = SCB_FULL;
					end
				end
				SCB_FULL: begin
					if (cur.wen_sync && cur.ren_sync) begin
						next_cur.mode = SCB_FROZEN;
					end else if (cur.ren_sync) begin
						// readout starts from the oldest sample, at the write pointer
						next_cur.mode = SCB_READ;
						next_cur.full = 1'b0;
						next_cur.rd_ptr = cur.wr_ptr;
						next_cur.rd_left = depth_bytes;
						next_cur.lat_cnt = '0;
						next_cur.pat_idx = '0;
						if (cfg_pattern) begin
							next_cur.ovr = 1'b1;
						end
					end
				end
				SCB_READ: begin
					if (cur.wen_sync) begin
						// capture request wins even over a readout in progress
						next_cur.mode = SCB_FROZEN;
					end else if (rck_rise && cur.ren_sync) begin
						if (cur.lat_cnt != READ_LATENCY - 2'h1) begin
							next_cur.lat_cnt = cur.lat_cnt + 2'h1;
						end else begin
							next_cur.strobe = ~cur.strobe;
							next_cur.sec_oe = cfg_dual;
							if (cfg_pattern) begin
								// pattern replaces stored data on the primary port, and on the secondary in two-port mode
								if (cfg_dual) begin
									next_cur.sec = PATTERN[cur.pat_idx];
									next_cur.prim = PATTERN[3'(cur.pat_idx + 3'h1)];
									next_cur.pat_idx = cur.pat_idx + 3'h2;
								end else begin
									next_cur.prim = PATTERN[cur.pat_idx];
									next_cur.pat_idx = cur.pat_idx + 3'h1;
								end
							end else if (cfg_dual) begin
								next_cur.sec = mem.rd_data_a;
								next_cur.prim = mem.rd_data_b;
							end else begin
								next_cur.prim = mem.rd_data_a;
							end
							next_cur.rd_ptr = (cur.rd_ptr + step) & addr_mask;
							next_cur.rd_left = cur.rd_left - COUNT_W'(step);
							// last word read: flag empty, stored data is gone
							if (cur.rd_left <= COUNT_W'(step)) begin
								next_cur.mode = SCB_IDLE;
								next_cur.empty = 1'b1;
								next_cur.ovr = 1'b0;
							end
						end
					end
				end
				SCB_FROZEN: begin
					// held until reset; nothing moves
					next_cur.mode = SCB_FROZEN;
				end
			endcase
		end
	end

	// state register, synchronous reset
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cur <= '0;
			cur.empty <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	// all outputs straight from state flops
	assign primary_output_port = cur.prim;
	assign secondary_output_port = cur.sec;
	assign secondary_output_enable = cur.sec_oe;
	assign output_strobe = cur.strobe;
	assign overrange = cur.ovr;
	assign capture_empty_flag = cur.empty;
	assign capture_full_flag = cur.full;
	assign capture_start_marker = cur.marker;

	// checks on the controller's own behaviour
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	a_full_at_depth: assert property (
		(write_now && !cur.full && cur.wr_count + 13'h0001 == depth_bytes) |=> cur.full
	) else $error("full flag not raised at selected depth");

	a_write_exclusive: assert property (
		mem.wr_en |-> (cur.mode == SCB_CAPTURE && !cur.empty)
	) else $error("write outside capture");

	a_stop_when_full: assert property (
		(cur.full && cfg_stop && !cur.rst_sync) |=> $stable(cur.wr_ptr)
	) else $error("write pointer moved after full with auto-stop");

	a_read_clears_full: assert property (
		(cur.mode == SCB_FULL && cur.ren_sync && !cur.wen_sync && !cur.rst_sync)
		|=> (cur.mode == SCB_READ && !cur.full)
	) else $error("readout did not start or full not cleared");

	a_capture_clears_empty: assert property (
		(cur.mode == SCB_IDLE && cur.wen_sync && !cur.rst_sync) |=> !cur.empty ##0 cur.mode == SCB_CAPTURE
	) else $error("capture did not clear empty");

	a_reset_flags: assert property (
		cur.rst_sync |=> (cur.empty && !cur.full && cur.mode == SCB_IDLE)
	) else $error("pin reset did not restore flags");

	a_frozen_holds: assert property (
		(cur.mode == SCB_FROZEN && !cur.rst_sync) |=> cur.mode == SCB_FROZEN
	) else $error("frozen buffer moved without reset");

	a_strobe_with_data: assert property (
		$changed(cur.prim) |-> $changed(cur.strobe)
	) else $error("data changed without strobe transition");

	a_secondary_released: assert property (
		($changed(cur.strobe) && !cfg_dual) |-> !cur.sec_oe
	) else $error("secondary driven in single-port mode");

	a_ovr_clears_empty: assert property (
		$rose(cur.empty) |-> !cur.ovr
	) else $error("overrange not cleared at empty");

	a_marker_follows: assert property (
		$rose(cur.wen_sync) |=> capture_start_marker
	) else $error("start marker missed capture request");

	a_flags_exclusive: assert property (
		!(cur.empty && cur.full)
	) else $error("empty and full flags both high");

	a_read_holds_wptr: assert property (
		(cur.mode == SCB_READ && !cur.rst_sync) |=> $stable(cur.wr_ptr)
	) else $error("write pointer moved during readout");

	a_pattern_ovr_high: assert property (
		(cur.mode == SCB_READ && cfg_pattern) |-> cur.ovr
	) else $error("overrange low during pattern output");

	a_latency_quiet: assert property (
		(cur.mode == SCB_READ && cur.lat_cnt != READ_LATENCY - 2'h1) |=> $stable(cur.strobe)
	) else $error("strobe moved before read latency elapsed");

	a_full_at_count: assert property (
		$rose(cur.full) |-> cur.wr_count == depth_bytes
	) else $error("full raised before selected depth written");

	a_strobe_in_read: assert property (
		$changed(cur.strobe) |-> $past(cur.mode) == SCB_READ
	) else $error("strobe moved outside readout");

	a_no_read_empty: assert property (
		(cur.empty && !cur.rst_sync) |=> $stable(cur.strobe)
	) else $error("word output after empty");

	a_ptr_in_depth: assert property (
		(cur.mode == SCB_CAPTURE) |-> (cur.wr_ptr & ~addr_mask) == '0
	) else $error("write pointer beyond selected depth");

endmodule
